// File: logic/cpu_interrupt_and_status_unit.sv
`timescale 1ns/1ps
`include "cpu_irq_consts.svh"

module cpu_interrupt_and_status_unit
  import cpu_irq_pkg::*;
#(
  parameter int         NUM_SRC   = 9,
  parameter logic [8:0] FLAG_TYPE = 9'h1ff,
  parameter int         IDXW      = $clog2(NUM_SRC)
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire io_req_t            ioReq,
  output logic      [7:0]         ioRdData,
  input  wire seq_t               seq,
  input  wire alu_flags_t         aluFlags,
  input  wire logic [NUM_SRC-1:0] srcEvent,
  input  wire logic [NUM_SRC-1:0] srcLevel,
  input  wire logic [NUM_SRC-1:0] srcEnable,
  input  wire logic [NUM_SRC-1:0] srcFlagClr,
  output logic      [NUM_SRC-1:0] srcFlags,
  output flags_t                  coreFlags,
  output logic      [15:0]        stackPointer,
  output logic                    protectOpen,
  output logic                    coreBusy,
  output logic                    pcPush,
  output logic                    pcPop,
  output logic                    vectorFetch,
  output logic      [IDXW-1:0]    acceptedSrc
);

  core_state_t       stateFF, nxt_state;
  logic [2:0]        cntFF, nxt_cnt;
  flags_t            flagsFF, nxt_flags;
  logic [15:0]       stackFF, nxt_stack;
  logic [2:0]        unlockFF, nxt_unlock;
  logic              openFF, nxt_open;
  logic              shadowFF, nxt_shadow;
  logic [7:0]        rdFF, nxt_rd;
  logic              busyFF, nxt_busy;
  logic              pushFF, nxt_push;
  logic              popFF, nxt_pop;
  logic              vecFF, nxt_vec;
  logic [IDXW-1:0]   srcFF, nxt_src;
  logic              pendingAny;
  logic [IDXW-1:0]   winIdx;
  logic              take;
  logic              boundary;
  logic              retDone;
  logic              entryDone;

  ////////////////////////////////////////////////////////////////////////////
  irq_source_bank #(
    .NUM_SRC   (NUM_SRC),
    .IDXW      (IDXW),
    .FLAG_TYPE (FLAG_TYPE)
  ) u_bank (
    .clk        (clk),
    .rstn       (rstn),
    .srcEvent   (srcEvent),
    .srcLevel   (srcLevel),
    .srcEnable  (srcEnable),
    .srcFlagClr (srcFlagClr),
    .ackValid   (take),
    .ackIdx     (winIdx),
    .srcFlags   (srcFlags),
    .pendingAny (pendingAny),
    .winIdx     (winIdx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // acceptance only at an instruction boundary or from sleep
  assign boundary  = seq.instrDone | seq.sleeping;
  assign take      = (stateFF == ST_IDLE) && boundary && pendingAny
                     && flagsFF.gie
                     && !seq.clearGlobal
                     && !seq.setGlobal && !shadowFF
                     && (unlockFF == 3'h0)
                     && !(seq.instrDone && seq.returnOp);
  assign retDone   = (stateFF == ST_RETURN) && (cntFF == 3'h0);
  assign entryDone = (stateFF == ST_ENTRY) && (cntFF == 3'h0);

  always_comb
  begin
    nxt_state = stateFF;
    nxt_cnt   = cntFF;
    nxt_src   = srcFF;
    nxt_push  = 1'b0;
    nxt_pop   = 1'b0;
    nxt_vec   = 1'b0;
    unique case (stateFF)
      ST_IDLE:
      begin
        if (take)
        begin
          nxt_src = winIdx;
          if (seq.sleeping)
          begin
            nxt_state = ST_WAKE;
            nxt_cnt   = `WAKE_EXTRA_CYCLES - 3'h1;
          end
          else
          begin
            nxt_state = ST_ENTRY;
            nxt_cnt   = `ENTRY_CYCLES - 3'h1;
            nxt_push  = 1'b1;
          end
        end
        else if (seq.instrDone && seq.returnOp)
        begin
          nxt_state = ST_RETURN;
          nxt_cnt   = `RETURN_CYCLES - 3'h1;
          nxt_pop   = 1'b1;
        end
      end
      ST_WAKE:
      begin
        nxt_cnt = cntFF - 3'h1;
        if (cntFF == 3'h0)
        begin
          nxt_state = ST_ENTRY;
          nxt_cnt   = `ENTRY_CYCLES - 3'h1;
          nxt_push  = 1'b1;
        end
      end
      ST_ENTRY:
      begin
        nxt_cnt = cntFF - 3'h1;
        if (cntFF == 3'h0)
        begin
          nxt_state = ST_JUMP;
          nxt_cnt   = `JUMP_CYCLES - 3'h1;
          nxt_vec   = 1'b1;
        end
      end
      ST_JUMP:
      begin
        nxt_cnt = cntFF - 3'h1;
        if (cntFF == 3'h0)
          nxt_state = ST_IDLE;
      end
      ST_RETURN:
      begin
        nxt_cnt = cntFF - 3'h1;
        if (cntFF == 3'h0)
          nxt_state = ST_IDLE;
      end
    endcase
    nxt_busy = (nxt_state != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stateFF <= ST_IDLE;
      cntFF   <= 3'h0;
      srcFF   <= '0;
      pushFF  <= 1'b0;
      popFF   <= 1'b0;
      vecFF   <= 1'b0;
      busyFF  <= 1'b0;
    end
    else
    begin
      stateFF <= nxt_state;
      cntFF   <= nxt_cnt;
      srcFF   <= nxt_src;
      pushFF  <= nxt_push;
      popFF   <= nxt_pop;
      vecFF   <= nxt_vec;
      busyFF  <= nxt_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, stack pointer, unlock window, one-instruction shadow
  always_comb
  begin
    nxt_flags  = flagsFF;
    nxt_stack  = stackFF;
    nxt_unlock = unlockFF;
    nxt_shadow = shadowFF;
    if (ioReq.wrEn && ioReq.addr == `OFS_CORE_FLAGS)
      nxt_flags = flags_t'(ioReq.wrData);
    if (aluFlags.we)
    begin
      nxt_flags.halfCarry = aluFlags.halfCarry;
      nxt_flags.overflow  = aluFlags.overflow;
      nxt_flags.negative  = aluFlags.negative;
      nxt_flags.zero      = aluFlags.zero;
      nxt_flags.carry     = aluFlags.carry;
    end
    if (seq.bitStore)
      nxt_flags.copyBit = seq.bitStoreVal;
    if (seq.instrDone && seq.setGlobal)
      nxt_flags.gie = 1'b1;
    if (seq.instrDone && seq.clearGlobal)
      nxt_flags.gie = 1'b0;
    if (take)
      nxt_flags.gie = 1'b0;
    if (retDone)
      nxt_flags.gie = 1'b1;
    nxt_flags.sign = nxt_flags.negative ^ nxt_flags.overflow;

    if (ioReq.wrEn && ioReq.addr == `OFS_STACK_PTR_LOW)
      nxt_stack[7:0] = ioReq.wrData;
    if (ioReq.wrEn && ioReq.addr == `OFS_STACK_PTR_HIGH)
      nxt_stack[15:8] = ioReq.wrData;
    if (seq.callPush)
      nxt_stack = nxt_stack - `STACK_STEP_WORD;
    if (seq.subReturn)
      nxt_stack = nxt_stack + `STACK_STEP_WORD;
    if (seq.pushByte)
      nxt_stack = nxt_stack - `STACK_STEP_BYTE;
    if (seq.popByte)
      nxt_stack = nxt_stack + `STACK_STEP_BYTE;
    if (entryDone)
      nxt_stack = stackFF - `STACK_STEP_WORD;
    if (retDone)
      nxt_stack = stackFF + `STACK_STEP_WORD;

    if (seq.instrDone && unlockFF != 3'h0)
      nxt_unlock = unlockFF - 3'h1;
    if (ioReq.wrEn && ioReq.addr == `OFS_CHANGE_PROTECT_KEY)
      nxt_unlock = (ioReq.wrData == `UNLOCK_KEY) ? `UNLOCK_WINDOW_INSTR : 3'h0;
    // window flag registered so the output comes from a flop
    nxt_open = (nxt_unlock != 3'h0);

    if (seq.instrDone)
      nxt_shadow = 1'b0;
    if (seq.instrDone && seq.setGlobal)
      nxt_shadow = 1'b1;
    if (retDone)
      nxt_shadow = 1'b1;

    nxt_rd = 8'h00;
    if (ioReq.rdEn)
    begin
      unique case (ioReq.addr)
        `OFS_CHANGE_PROTECT_KEY: nxt_rd = {7'h00, unlockFF != 3'h0};
        `OFS_STACK_PTR_LOW:      nxt_rd = stackFF[7:0];
        `OFS_STACK_PTR_HIGH:     nxt_rd = stackFF[15:8];
        `OFS_CORE_FLAGS:         nxt_rd = flagsFF;
        default:                 nxt_rd = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flagsFF  <= flags_t'(`RST_CORE_FLAGS);
      stackFF  <= `SRAM_LAST_ADDRESS;
      unlockFF <= 3'h0;
      openFF   <= 1'b0;
      shadowFF <= 1'b0;
      rdFF     <= 8'h00;
    end
    else
    begin
      flagsFF  <= nxt_flags;
      stackFF  <= nxt_stack;
      unlockFF <= nxt_unlock;
      openFF   <= nxt_open;
      shadowFF <= nxt_shadow;
      rdFF     <= nxt_rd;
    end
  end

  assign ioRdData     = rdFF;
  assign coreFlags    = flagsFF;
  assign stackPointer = stackFF;
  assign protectOpen  = openFF;
  assign coreBusy     = busyFF;
  assign pcPush       = pushFF;
  assign pcPop        = popFF;
  assign vectorFetch  = vecFF;
  assign acceptedSrc  = srcFF;

  ////////////////////////////////////////////////////////////////////////////
  property p_enable_needed;
    @(posedge clk) disable iff (!rstn)
    $rose(busyFF) && !$past(seq.returnOp) |-> $past(flagsFF.gie);
  endproperty
  a_enable_needed: assert property (p_enable_needed) else $error("entry without enable");

  property p_entry_clears;
    @(posedge clk) disable iff (!rstn)
    (stateFF == ST_IDLE) && take |=> !flagsFF.gie;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("enable kept on entry");

  property p_clear_blocks;
    @(posedge clk) disable iff (!rstn)
    seq.instrDone && seq.clearGlobal && stateFF == ST_IDLE |=> stateFF == ST_IDLE;
  endproperty
  a_clear_blocks: assert property (p_clear_blocks) else $error("taken at clear");

  property p_shadow_blocks;
    @(posedge clk) disable iff (!rstn)
    shadowFF && stateFF == ST_IDLE |=> stateFF inside {ST_IDLE, ST_RETURN};
  endproperty
  a_shadow_blocks: assert property (p_shadow_blocks) else $error("no instruction slot");

  property p_entry_len;
    @(posedge clk) disable iff (!rstn)
    $rose(stateFF == ST_ENTRY) |-> (stateFF == ST_ENTRY)[*4] ##1 (stateFF == ST_JUMP)[*3];
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry length wrong");

  property p_wake_len;
    @(posedge clk) disable iff (!rstn)
    $rose(stateFF == ST_WAKE) |-> (stateFF == ST_WAKE)[*4] ##1 stateFF == ST_ENTRY;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake length wrong");

  property p_return_seq;
    @(posedge clk) disable iff (!rstn)
    $rose(stateFF == ST_RETURN) |-> (stateFF == ST_RETURN)[*4]
      ##1 (flagsFF.gie && stackFF == $past(stackFF, 4) + 16'h0002);
  endproperty
  a_return_seq: assert property (p_return_seq) else $error("return sequence wrong");

  property p_unlock_opens;
    @(posedge clk) disable iff (!rstn)
    ioReq.wrEn && ioReq.addr == `OFS_CHANGE_PROTECT_KEY && ioReq.wrData == `UNLOCK_KEY
      |=> protectOpen;
  endproperty
  a_unlock_opens: assert property (p_unlock_opens) else $error("window not open");

  property p_unlock_ignores;
    @(posedge clk) disable iff (!rstn)
    protectOpen && stateFF == ST_IDLE |=> !(stateFF inside {ST_ENTRY, ST_WAKE});
  endproperty
  a_unlock_ignores: assert property (p_unlock_ignores) else $error("taken in window");

  property p_key_read;
    @(posedge clk) disable iff (!rstn)
    ioReq.rdEn && ioReq.addr == `OFS_CHANGE_PROTECT_KEY |=> ioRdData == {7'h00, $past(protectOpen)};
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read wrong");

  property p_sign;
    @(posedge clk) disable iff (!rstn)
    coreFlags.sign == (coreFlags.negative ^ coreFlags.overflow);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

endmodule : cpu_interrupt_and_status_unit

// File: logic/irq_source_bank.sv
`timescale 1ns/1ps

module irq_source_bank #(
  parameter int          NUM_SRC   = 9,
  parameter int          IDXW      = 4,
  parameter logic [8:0]  FLAG_TYPE = 9'h1ff
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [NUM_SRC-1:0] srcEvent,
  input  wire logic [NUM_SRC-1:0] srcLevel,
  input  wire logic [NUM_SRC-1:0] srcEnable,
  input  wire logic [NUM_SRC-1:0] srcFlagClr,
  input  wire logic               ackValid,
  input  wire logic [IDXW-1:0]    ackIdx,
  output logic      [NUM_SRC-1:0] srcFlags,
  output logic                    pendingAny,
  output logic      [IDXW-1:0]    winIdx
);

  logic [NUM_SRC-1:0] flagFF;
  logic [NUM_SRC-1:0] nxt_flag;
  logic [NUM_SRC-1:0] request;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      always_comb
      begin
        nxt_flag[g] = flagFF[g];
        if (ackValid && ackIdx == IDXW'(g))
          nxt_flag[g] = 1'b0;
        if (srcFlagClr[g])
          nxt_flag[g] = 1'b0;
        if (srcEvent[g] && FLAG_TYPE[g])
          nxt_flag[g] = 1'b1;
      end
      // flag types hold, level types only while present
      assign request[g] = srcEnable[g] & (FLAG_TYPE[g] ? flagFF[g] : srcLevel[g]);
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flagFF <= '0;
    else
      flagFF <= nxt_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lowest index is the lowest vector and wins
  always_comb
  begin
    winIdx     = '0;
    pendingAny = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (request[i])
      begin
        winIdx     = IDXW'(i);
        pendingAny = 1'b1;
      end
    end
  end

  assign srcFlags = flagFF;

endmodule : irq_source_bank

// File: shared/cpu_irq_consts.svh
`ifndef CPU_IRQ_CONSTS_SVH
`define CPU_IRQ_CONSTS_SVH

// i/o addresses of the core registers
`define OFS_CHANGE_PROTECT_KEY 6'h3c
`define OFS_STACK_PTR_LOW      6'h3d
`define OFS_STACK_PTR_HIGH     6'h3e
`define OFS_CORE_FLAGS         6'h3f

// reset values
`define RST_CHANGE_PROTECT_KEY 8'h00
`define RST_CORE_FLAGS         8'h00
`define SRAM_LAST_ADDRESS      16'h005f

// unlock key and window length in instructions
`define UNLOCK_KEY             8'hd8
`define UNLOCK_WINDOW_INSTR    3'h4
`define KEY_OPEN_BIT           0

// sequencing lengths in core clock cycles
`define ENTRY_CYCLES           3'h4
`define JUMP_CYCLES            3'h3
`define WAKE_EXTRA_CYCLES      3'h4
`define RETURN_CYCLES          3'h4

// stack pointer steps
`define STACK_STEP_WORD        16'h0002
`define STACK_STEP_BYTE        16'h0001

`endif

// File: shared/cpu_irq_pkg.sv
package cpu_irq_pkg;

  typedef struct packed {
    logic gie;
    logic copyBit;
    logic halfCarry;
    logic sign;
    logic overflow;
    logic negative;
    logic zero;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic       we;
    logic       halfCarry;
    logic       overflow;
    logic       negative;
    logic       zero;
    logic       carry;
  } alu_flags_t;

  typedef struct packed {
    logic [5:0] addr;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] wrData;
  } io_req_t;

  typedef struct packed {
    logic instrDone;
    logic clearGlobal;
    logic setGlobal;
    logic returnOp;
    logic callPush;
    logic subReturn;
    logic pushByte;
    logic popByte;
    logic bitStore;
    logic bitStoreVal;
    logic sleeping;
  } seq_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAKE,
    ST_ENTRY,
    ST_JUMP,
    ST_RETURN
  } core_state_t;

endpackage : cpu_irq_pkg

// File: verification/cpu_interrupt_and_status_unit_test.sv
`timescale 1ns/1ps

module cpu_interrupt_and_status_unit_test
  import cpu_irq_pkg::*;
;
  localparam seq_t DONE  = 11'h400;
  localparam seq_t CLR   = 11'h200;
  localparam seq_t SET   = 11'h100;
  localparam seq_t RET   = 11'h080;
  localparam seq_t STORE = 11'h004;
  localparam seq_t BVAL  = 11'h002;
  localparam seq_t SLEEP = 11'h001;

  logic        clk;
  logic        rstn;
  io_req_t     ioReq;
  logic [7:0]  ioRdData;
  seq_t        seq;
  alu_flags_t  aluFlags;
  logic [8:0]  srcEvent;
  logic [8:0]  srcLevel;
  logic [8:0]  srcEnable;
  logic [8:0]  srcFlagClr;
  logic [8:0]  srcFlags;
  flags_t      coreFlags;
  logic [15:0] stackPointer;
  logic        protectOpen;
  logic        coreBusy;
  logic        pcPush;
  logic        pcPop;
  logic        vectorFetch;
  logic [3:0]  acceptedSrc;
  logic [8:0]  fire;
  logic [8:0]  hold;
  logic        protWr;
  logic [7:0]  protData;
  logic [7:0]  clockMain;
  int          failures;
  int          total_checks;
  seq_t        stackOps [4] = '{11'h040, 11'h010, 11'h008, 11'h020};
  logic [15:0] stackExp [4] = '{16'h013e, 16'h013d, 16'h013e, 16'h0140};

  cpu_interrupt_and_status_unit #(.NUM_SRC(9), .FLAG_TYPE(9'h0ff)) i_dut (
    .clk(clk), .rstn(rstn), .ioReq(ioReq), .ioRdData(ioRdData), .seq(seq),
    .aluFlags(aluFlags), .srcEvent(srcEvent), .srcLevel(srcLevel), .srcEnable(srcEnable),
    .srcFlagClr(srcFlagClr), .srcFlags(srcFlags), .coreFlags(coreFlags),
    .stackPointer(stackPointer), .protectOpen(protectOpen), .coreBusy(coreBusy),
    .pcPush(pcPush), .pcPop(pcPop), .vectorFetch(vectorFetch), .acceptedSrc(acceptedSrc)
  );

  irq_far_model i_far (
    .clk(clk), .rstn(rstn), .fire(fire), .hold(hold), .protectOpen(protectOpen),
    .protWr(protWr), .protData(protData), .srcEvent(srcEvent), .srcLevel(srcLevel),
    .clockMain(clockMain)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    ioReq <= '{addr: a, wrEn: 1'b1, rdEn: 1'b0, wrData: d};
    @(posedge clk);
    ioReq <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    ioReq <= '{addr: a, wrEn: 1'b0, rdEn: 1'b1, wrData: 8'h00};
    @(posedge clk);
    ioReq <= '0;
    #1;
    check(what, {8'h00, exp}, {8'h00, ioRdData});
  endtask : rd

  task automatic step(input seq_t s);
    @(posedge clk);
    seq <= s;
    @(posedge clk);
    seq <= '0;
    #1;
  endtask : step

  task automatic ev(input logic [8:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= '0;
    @(posedge clk);
    #1;
  endtask : ev

  task automatic busy(input string what, input int n);
    int cnt;
    cnt = 0;
    while (coreBusy === 1'b1 && cnt < 40)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check(what, n[15:0], cnt[15:0]);
    if (cnt == 40)
      test_done();
  endtask : busy

  task automatic idle();
    check("busy", 16'h0000, {15'h0, coreBusy});
  endtask : idle

  task automatic entry(input logic [3:0] idx, input int n);
    check("gie", 16'h0000, {15'h0, coreFlags.gie});
    check("source", {12'h000, idx}, {12'h000, acceptedSrc});
    repeat (n - 3) @(posedge clk);
    #1;
    check("vector", 16'h0001, {15'h0, vectorFetch});
    busy("busy len", 3);
  endtask : entry

  ////////////////////////////////////////
  initial
  begin
    failures = 0;
    total_checks = 0;
    rstn = 1'b0;
    ioReq = '0;
    seq = '0;
    aluFlags = '0;
    srcEnable = '0;
    srcFlagClr = '0;
    fire = '0;
    hold = '0;
    protWr = 1'b0;
    protData = 8'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(6'h3c, 8'h00, "key");
    rd(6'h3d, 8'h5f, "stack low");
    rd(6'h3e, 8'h00, "stack high");
    rd(6'h3f, 8'h00, "flags");
    rd(6'h10, 8'h00, "unmapped");
    wr(6'h3f, 8'h7f);
    rd(6'h3f, 8'h6f, "flags rw");
    wr(6'h3f, 8'h08);
    rd(6'h3f, 8'h18, "sign");
    @(posedge clk);
    aluFlags <= 6'h27;
    @(posedge clk);
    aluFlags <= '0;
    #1;
    check("alu", 16'h0017, {8'h00, coreFlags});
    step(STORE | BVAL);
    check("copy", 16'h0057, {8'h00, coreFlags});
    step(STORE);
    check("copy", 16'h0017, {8'h00, coreFlags});
    wr(6'h3d, 8'h40);
    wr(6'h3e, 8'h01);
    check("stack", 16'h0140, stackPointer);
    foreach (stackOps[i])
    begin
      step(stackOps[i]);
      check("stack op", stackExp[i], stackPointer);
    end
    // pending events while interrupts are off
    wr(6'h3f, 8'h00);
    @(posedge clk);
    srcEnable <= 9'h1df;
    ev(9'h02a);
    check("flags held", 16'h002a, {7'h00, srcFlags});
    step(DONE);
    idle();
    wr(6'h3f, 8'h80);
    step(DONE | CLR);
    idle();
    step(DONE | SET);
    idle();
    step(DONE);
    idle();
    step(DONE);
    check("push", 16'h0001, {15'h0, pcPush});
    check("flag ack", 16'h0028, {7'h00, srcFlags});
    entry(4'h1, 7);
    check("stack entry", 16'h013e, stackPointer);
    step(DONE | RET);
    check("pop", 16'h0001, {15'h0, pcPop});
    busy("return", 4);
    check("gie ret", 16'h0001, {15'h0, coreFlags.gie});
    check("stack ret", 16'h0140, stackPointer);
    step(DONE);
    idle();
    step(DONE);
    entry(4'h3, 7);
    @(posedge clk);
    srcFlagClr <= 9'h020;
    @(posedge clk);
    srcFlagClr <= '0;
    #1;
    check("w1c", 16'h0000, {7'h00, srcFlags});
    // level request that goes away unserved
    @(posedge clk);
    hold <= 9'h100;
    repeat (3) @(posedge clk);
    hold <= '0;
    repeat (3) @(posedge clk);
    wr(6'h3f, 8'h80);
    step(DONE);
    idle();
    @(posedge clk);
    hold <= 9'h100;
    repeat (3) @(posedge clk);
    step(DONE);
    entry(4'h8, 7);
    @(posedge clk);
    hold <= '0;
    wr(6'h3f, 8'h80);
    // unlock window
    wr(6'h3c, 8'hd8);
    rd(6'h3c, 8'h01, "key open");
    @(posedge clk);
    protWr <= 1'b1;
    protData <= 8'h5a;
    @(posedge clk);
    protWr <= 1'b0;
    ev(9'h002);
    check("guarded", 16'h005a, {8'h00, clockMain});
    repeat (4)
    begin
      step(DONE);
      idle();
    end
    check("open", 16'h0000, {15'h0, protectOpen});
    rd(6'h3c, 8'h00, "key shut");
    step(DONE);
    entry(4'h1, 7);
    @(posedge clk);
    protWr <= 1'b1;
    protData <= 8'ha5;
    @(posedge clk);
    protWr <= 1'b0;
    #1;
    check("guarded", 16'h005a, {8'h00, clockMain});
    // wake from sleep
    wr(6'h3f, 8'h80);
    ev(9'h004);
    idle();
    step(SLEEP);
    entry(4'h2, 11);
    test_done();
  end
endmodule : cpu_interrupt_and_status_unit_test

// File: verification/irq_far_model.sv
`timescale 1ns/1ps

module irq_far_model
  import cpu_irq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [8:0] fire,
  input  wire logic [8:0] hold,
  input  wire logic       protectOpen,
  input  wire logic       protWr,
  input  wire logic [7:0] protData,
  output logic      [8:0] srcEvent,
  output logic      [8:0] srcLevel,
  output logic      [7:0] clockMain
);
  logic [8:0] pulse_ff;
  logic [8:0] nxt_pulse;
  logic [8:0] level_ff;
  logic [8:0] nxt_level;
  logic [7:0] clockMain_ff;
  logic [7:0] nxt_clockMain;

  ////////////////////////////////////////
  // one-cycle event pulses, level requests, guarded register
  always_comb
  begin
    nxt_pulse     = fire;
    nxt_level     = hold;
    nxt_clockMain = clockMain_ff;
    if (protWr && protectOpen)
      nxt_clockMain = protData;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulse_ff     <= '0;
      level_ff     <= '0;
      clockMain_ff <= 8'h00;
    end
    else
    begin
      pulse_ff     <= nxt_pulse;
      level_ff     <= nxt_level;
      clockMain_ff <= nxt_clockMain;
    end
  end

  assign srcEvent  = pulse_ff;
  assign srcLevel  = level_ff;
  assign clockMain = clockMain_ff;
endmodule : irq_far_model
